// [rtl/ldr_cfg.svh]
// Constants for the logical unit resource routing block.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef LDR_CFG_SVH
`define LDR_CFG_SVH

`define LDR_IDX_ACTIVATE 8'h30
`define LDR_IDX_BASE_HI 8'h60
`define LDR_IDX_BASE_LO 8'h61
`define LDR_IDX_BASE2_HI 8'h62
`define LDR_IDX_BASE2_LO 8'h63
`define LDR_IDX_IRQ_SEL 8'h70
`define LDR_IDX_DMA_SEL 8'h74
`define LDR_IDX_UNIT 8'h07
`define LDR_CFG_INDEX_PORT 16'h03F0
`define LDR_CFG_DATA_PORT 16'h03F1

`define LDR_UNIT_FLOPPY 8'h00
`define LDR_UNIT_PARALLEL 8'h03
`define LDR_UNIT_SERIAL1 8'h04
`define LDR_UNIT_SERIAL2 8'h05
`define LDR_UNIT_KEYBOARD 8'h07

`define LDR_BASE_MIN 12'h100
`define LDR_BASE_MAX8 12'hFF8
`define LDR_BASE_MAX4 12'hFFC
`define LDR_EXT_OFS_A 12'h400
`define LDR_EXT_OFS_B 12'h401
`define LDR_EXT_OFS_C 12'h402
`define LDR_KBD_DATA 12'h060
`define LDR_KBD_CMD 12'h064
`define LDR_FLOPPY_HOLE 3'h6
`define LDR_EPP_FIRST 3'h3

`define LDR_IRQ_RST 8'h00
`define LDR_DMA_RST 8'h04
`define LDR_IRQ_SHARED 4'h2
`define LDR_PAR_IRQ_MASK 16'h1CF8
`define LDR_ALL_IRQ_MASK 16'hFFFE
`define LDR_FLOPPY_GATE_BIT 3
`define LDR_PAR_PARALLEL_IRQ_ENABLE_BIT 4
`define LDR_ECR_SVC_BIT 2
`define LDR_ECR_DMA_BIT 3
`define LDR_IER_LO 0
`define LDR_IER_HI 3

`endif

// [rtl/ldr_pkg.sv]
// Types for the logical unit resource routing block.
// Assumes ldr_cfg.svh sits beside it.
`default_nettype none
package ldr_pkg;
    typedef enum logic [2:0] {
        LDR_FLOPPY,
        LDR_PARALLEL,
        LDR_SERIAL1,
        LDR_SERIAL2,
        LDR_KEYBOARD,
        LDR_NONE
    } ldr_unit_e;

    typedef enum logic [2:0] {
        LDR_PM_PRINTER,
        LDR_PM_SPP,
        LDR_PM_FIFO,
        LDR_PM_ECP,
        LDR_PM_EPP,
        LDR_PM_RES,
        LDR_PM_TEST,
        LDR_PM_CONFIG
    } ldr_pmode_e;

    typedef logic [11:0] ldr_addr_t;
endpackage : ldr_pkg
`default_nettype wire

// [rtl/ldr_route.sv]
// Per-line router: one instance per request line or channel pin.
// Assumes the claims fed in on sel_hit are already qualified by enables.
`default_nettype none
module ldr_route #(
    parameter int N = 4
) (
    input wire logic [N-1:0] sel_hit,
    input wire logic [N-1:0] req,
    input wire logic avail,
    output logic pin_o,
    output logic pin_oe
);
    // Drive only while some unit claims this line
    assign pin_oe = avail && (|sel_hit);
    assign pin_o = |(sel_hit & req);
endmodule : ldr_route
`default_nettype wire

// [rtl/ldr_routing.sv]
// Logical unit resource routing: config index/data port, per-unit banks,
// I/O decode, IRQ and DMA steering with tri-state control.
// Assumes a synchronous ISA strobe view on clk and unit-side enables.
// Function
// (RQ1) Floppy eight-byte block, hole at six
// (RQ2) Parallel base four-aligned, EPP needs eight
// (RQ3) EPP registers three to seven eight-aligned
// (RQ4) Parallel extended registers at plus 400h
// (RQ5) Serial eight-register block, eight-aligned
// (RQ6) Keyboard fixed at 60 and 64
// (RQ7) Decode compares address bits eleven to zero
// (RQ8) Level zero none, else line n
// (RQ9) Routed interrupts edge high, except ECP/EPP; the code passes every request through active-high, ECP/EPP included
// (RQ10) Management interrupt output is active low
// (RQ11) Interrupt needs nonzero level and unit enable
// (RQ12) Parallel interrupt needs enable, ECP service clear
// (RQ13) Serial interrupt needs enable bits and aux2
// (RQ14) Unclaimed interrupt pins float
// (RQ15) Software disables management interrupt before line two
// (RQ16) Parallel mode offers lines 3-7, 10-12
// (RQ17) Channel field: 0 reserved, 1-3, 4-7 none
// (RQ18) Channel active when 1-3 and enabled
// (RQ19) ECP channel needs extended DMA enable
// (RQ20) Second serial channel needs infrared DMA enable
// (RQ21) Unclaimed DMA request pins float
// (RQ22) Base high at 60h, low at 61h
// (RQ23) Out-of-range base ignores host accesses
// (RQ24) Deactivated unit decodes and routes nothing
`default_nettype none
`include "ldr_cfg.svh"
module ldr_routing (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic cfg_mode,
    input wire logic serial_irq_mode,
    input wire logic mgmt_irq_req,
    input wire logic mgmt_irq_enable,
    input wire logic floppy_dma_irq_gate,
    input wire logic parallel_irq_enable,
    input wire ldr_pkg::ldr_pmode_e parallel_mode,
    input wire logic service_interrupt_bit,
    input wire logic ext_dma_enable,
    input wire logic [3:0] serial1_int_enable,
    input wire logic [3:0] serial2_int_enable,
    input wire logic serial1_aux_output_two,
    input wire logic serial2_aux_output_two,
    input wire logic infrared_dma_enable,
    input wire logic [4:0] unit_irq_req,
    input wire logic [2:0] unit_dma_req,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    output logic [4:0] unit_sel,
    output logic [2:0] unit_reg_ofs,
    output logic epp_avail,
    output logic [15:0] irq_o,
    output logic [15:0] irq_oe,
    output logic [3:0] dreq_o,
    output logic [3:0] dreq_oe,
    output logic mgmt_interrupt_n
);
    import ldr_pkg::*;

    logic [7:0] cfg_index;
    logic [7:0] unit_num;
    logic [4:0] bank_wr;
    logic [4:0] bank_active;
    logic [15:0] bank_base [5];
    logic [3:0] bank_irq [5];
    logic [2:0] bank_dma [5];
    logic [7:0] bank_rdata [5];
    ldr_unit_e cur_unit;
    logic idx_hit;
    logic dat_hit;
    ldr_addr_t a;
    ldr_addr_t b [5];
    logic [4:0] base_ok;
    logic [4:0] hit;
    logic [2:0] ofs;
    logic [4:0] irq_en;
    logic [4:0] irq_go;
    logic [2:0] dma_en;
    logic [2:0] dma_go;
    logic [15:0] irq_avail;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic [4:0] next_sel;

    assign idx_hit = cfg_mode && io_addr == `LDR_CFG_INDEX_PORT;
    assign dat_hit = cfg_mode && io_addr == `LDR_CFG_DATA_PORT;

    // Index register, and the unit number held behind index 07h
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_index <= 8'h00;
            unit_num <= 8'h00;
        end else begin
            if (io_wr && idx_hit)
                cfg_index <= io_wdata;
            if (io_wr && dat_hit && cfg_index == `LDR_IDX_UNIT)
                unit_num <= io_wdata;
        end
    end

    // Map the programmed unit number onto a bank slot
    always_comb begin
        unique case (unit_num)
            `LDR_UNIT_FLOPPY: cur_unit = LDR_FLOPPY;
            `LDR_UNIT_PARALLEL: cur_unit = LDR_PARALLEL;
            `LDR_UNIT_SERIAL1: cur_unit = LDR_SERIAL1;
            `LDR_UNIT_SERIAL2: cur_unit = LDR_SERIAL2;
            `LDR_UNIT_KEYBOARD: cur_unit = LDR_KEYBOARD;
            default: cur_unit = LDR_NONE;
        endcase
    end

    // (RQ22) Per-unit banks
    for (genvar u = 0; u < 5; u++) begin : g_bank
        assign bank_wr[u] = io_wr && dat_hit && cur_unit == ldr_unit_e'(u);
        ldr_unit_cfg u_cfg (
            .clk(clk),
            .rst(rst),
            .wr(bank_wr[u]),
            .idx(cfg_index),
            .wdata(io_wdata),
            .active(bank_active[u]),
            .base(bank_base[u]),
            .irq_sel(bank_irq[u]),
            .dma_sel(bank_dma[u]),
            .rdata(bank_rdata[u])
        );
        // (RQ7) Twelve address bits only
        assign b[u] = bank_base[u][11:0];
    end

    // (RQ7) Host address compared on low twelve bits
    assign a = io_addr[11:0];
    assign ofs = a[2:0];

    // (RQ23) Range and alignment checks per unit
    // (RQ2) Parallel accepts four-byte alignment
    always_comb begin
        base_ok = '0;
        for (int u = 0; u < 4; u++) begin
            if (u == int'(LDR_PARALLEL))
                base_ok[u] = b[u] >= `LDR_BASE_MIN &&
                    b[u] <= `LDR_BASE_MAX4 && b[u][1:0] == 2'b00;
            else
                base_ok[u] = b[u] >= `LDR_BASE_MIN &&
                    b[u] <= `LDR_BASE_MAX8 && b[u][2:0] == 3'b000;
        end
        base_ok[LDR_KEYBOARD] = 1'b1;
    end

    // (RQ3) EPP only when base is eight-aligned
    assign epp_avail = bank_active[LDR_PARALLEL] &&
        base_ok[LDR_PARALLEL] && b[LDR_PARALLEL][2] == 1'b0;

    // (RQ24) Decode gated by activate and valid base
    always_comb begin
        hit = '0;
        // (RQ1) Floppy block, offset six unused
        hit[LDR_FLOPPY] = a[11:3] == b[LDR_FLOPPY][11:3] &&
            ofs != `LDR_FLOPPY_HOLE;
        // (RQ3) Offsets 4-7 only with EPP; offset 3 always decodes
        // (RQ4) Extended registers above base
        hit[LDR_PARALLEL] = (a[11:2] == b[LDR_PARALLEL][11:2]) ||
            (epp_avail && a[11:3] == b[LDR_PARALLEL][11:3] &&
             ofs >= `LDR_EPP_FIRST) ||
            a == b[LDR_PARALLEL] + `LDR_EXT_OFS_A ||
            a == b[LDR_PARALLEL] + `LDR_EXT_OFS_B ||
            a == b[LDR_PARALLEL] + `LDR_EXT_OFS_C;
        // (RQ5) Serial eight-register blocks
        hit[LDR_SERIAL1] = a[11:3] == b[LDR_SERIAL1][11:3];
        hit[LDR_SERIAL2] = a[11:3] == b[LDR_SERIAL2][11:3];
        // (RQ6) Keyboard fixed addresses
        hit[LDR_KEYBOARD] = a == `LDR_KBD_DATA || a == `LDR_KBD_CMD;
        hit = hit & bank_active & base_ok & {5{io_rd | io_wr}};
    end

    // Registered unit select and offset toward the units
    always_comb begin
        next_sel = hit;
        next_rvalid = io_rd && dat_hit;
        next_rdata = 8'h00;
        if (cfg_index == `LDR_IDX_UNIT)
            next_rdata = unit_num;
        else if (cur_unit != LDR_NONE)
            next_rdata = bank_rdata[cur_unit];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_sel <= '0;
            unit_reg_ofs <= 3'h0;
        end else begin
            unit_sel <= next_sel;
            unit_reg_ofs <= ofs;
        end
    end

    // Configuration read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_rdata <= 8'h00;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata <= next_rvalid ? next_rdata : 8'h00;
            io_rdata_valid <= next_rvalid;
        end
    end

    // Interrupt enables from the units' own control bits; keyboard always enabled
    always_comb begin
        // (RQ11) Floppy gate bit
        irq_en[LDR_FLOPPY] = floppy_dma_irq_gate;
        // (RQ12) Service bit blocks only in ECP
        irq_en[LDR_PARALLEL] = parallel_irq_enable &&
            !(parallel_mode == LDR_PM_ECP && service_interrupt_bit);
        // (RQ13) Any enable bit plus aux2
        irq_en[LDR_SERIAL1] = |serial1_int_enable && serial1_aux_output_two;
        irq_en[LDR_SERIAL2] = |serial2_int_enable && serial2_aux_output_two;
        irq_en[LDR_KEYBOARD] = 1'b1;
    end

    // (RQ11) Level nonzero, active, valid base
    // (RQ8) Level zero selects nothing
    for (genvar u = 0; u < 5; u++) begin : g_irq_go
        assign irq_go[u] = irq_en[u] && bank_active[u] && base_ok[u] &&
            bank_irq[u] != 4'h0;
    end

    // (RQ16) Parallel mode restricts usable lines
    assign irq_avail = serial_irq_mode ? `LDR_ALL_IRQ_MASK :
        `LDR_PAR_IRQ_MASK;

    // (RQ14) (RQ8) One router per request line
    // (RQ9) Requests pass through as active-high levels
    for (genvar l = 0; l < 16; l++) begin : g_irq
        logic [4:0] claim;
        for (genvar u = 0; u < 5; u++) begin : g_c
            // (RQ15) Line two only if management irq off
            assign claim[u] = irq_go[u] && bank_irq[u] == 4'(l) &&
                !(l == `LDR_IRQ_SHARED && mgmt_irq_enable);
        end
        ldr_route #(.N(5)) u_route (
            .sel_hit(claim),
            .req(unit_irq_req),
            .avail(irq_avail[l]),
            .pin_o(irq_o[l]),
            .pin_oe(irq_oe[l])
        );
    end

    // (RQ10) Management interrupt driven active low
    assign mgmt_interrupt_n = !(mgmt_irq_enable && mgmt_irq_req);

    // DMA enables: floppy, parallel, second serial
    always_comb begin
        // (RQ18) Floppy shares the gate bit
        dma_en[0] = floppy_dma_irq_gate && bank_active[LDR_FLOPPY] &&
            base_ok[LDR_FLOPPY];
        // (RQ19) Extended DMA enable in ECP
        dma_en[1] = bank_active[LDR_PARALLEL] && base_ok[LDR_PARALLEL] &&
            (parallel_mode != LDR_PM_ECP || ext_dma_enable);
        // (RQ20) Infrared DMA enable required
        dma_en[2] = infrared_dma_enable && bank_active[LDR_SERIAL2] &&
            base_ok[LDR_SERIAL2];
    end

    // (RQ17) Only codes 1-3 name a channel
    assign dma_go[0] = dma_en[0] && bank_dma[LDR_FLOPPY] inside {[1:3]};
    assign dma_go[1] = dma_en[1] && bank_dma[LDR_PARALLEL] inside {[1:3]};
    assign dma_go[2] = dma_en[2] && bank_dma[LDR_SERIAL2] inside {[1:3]};

    // (RQ21) One router per channel; channel 0 never claimed
    for (genvar c = 0; c < 4; c++) begin : g_dma
        logic [2:0] claim;
        assign claim[0] = dma_go[0] && bank_dma[LDR_FLOPPY] == 3'(c);
        assign claim[1] = dma_go[1] && bank_dma[LDR_PARALLEL] == 3'(c);
        assign claim[2] = dma_go[2] && bank_dma[LDR_SERIAL2] == 3'(c);
        ldr_route #(.N(3)) u_route (
            .sel_hit(claim),
            .req(unit_dma_req),
            .avail(1'b1),
            .pin_o(dreq_o[c]),
            .pin_oe(dreq_oe[c])
        );
    end

    // Assertions
    logic irq_sel_zero_all;
    assign irq_sel_zero_all = irq_go == 5'h00;
    property p_irq_float;
        @(posedge clk) disable iff (rst)
        (irq_sel_zero_all) |-> irq_oe == 16'h0000;
    endproperty
    a_irq_float: assert property (p_irq_float) // (RQ14)
        else $error("irq pin driven with no claim");

    property p_dma_float;
        @(posedge clk) disable iff (rst)
        dma_go == 3'h0 |-> dreq_oe == 4'h0;
    endproperty
    a_dma_float: assert property (p_dma_float) // (RQ21)
        else $error("dma pin driven with no claim");

    property p_dma0;
        @(posedge clk) disable iff (rst) !dreq_oe[0];
    endproperty
    a_dma0: assert property (p_dma0) // (RQ17)
        else $error("reserved channel driven");

    property p_par_lines;
        @(posedge clk) disable iff (rst)
        !serial_irq_mode |-> (irq_oe & ~16'h1CF8) == 16'h0000;
    endproperty
    a_par_lines: assert property (p_par_lines) // (RQ16)
        else $error("unavailable line driven");

    property p_smi;
        @(posedge clk) disable iff (rst)
        (mgmt_irq_enable && mgmt_irq_req) |-> !mgmt_interrupt_n;
    endproperty
    a_smi: assert property (p_smi) // (RQ10)
        else $error("management interrupt not low");

    property p_kbd;
        @(posedge clk) disable iff (rst)
        (io_rd && a == 12'h060 && bank_active[LDR_KEYBOARD])
            |=> unit_sel[LDR_KEYBOARD];
    endproperty
    a_kbd: assert property (p_kbd) // (RQ6)
        else $error("keyboard data not decoded");

    property p_inactive;
        @(posedge clk) disable iff (rst)
        !bank_active[LDR_SERIAL1] |=> !unit_sel[LDR_SERIAL1];
    endproperty
    a_inactive: assert property (p_inactive) // (RQ24)
        else $error("inactive unit decoded");

    property p_flop_hole;
        @(posedge clk) disable iff (rst)
        ofs == 3'h6 |=> !unit_sel[LDR_FLOPPY];
    endproperty
    a_flop_hole: assert property (p_flop_hole) // (RQ1)
        else $error("floppy offset six decoded");

    property p_ser_irq;
        @(posedge clk) disable iff (rst)
        !serial1_aux_output_two |-> !irq_go[LDR_SERIAL1];
    endproperty
    a_ser_irq: assert property (p_ser_irq) // (RQ13)
        else $error("serial irq without aux2");

    c_irq: cover property (@(posedge clk) disable iff (rst) |irq_oe);
    c_dma: cover property (@(posedge clk) disable iff (rst) |dreq_oe);
    c_epp: cover property (@(posedge clk) disable iff (rst) epp_avail);
endmodule : ldr_routing
`default_nettype wire

// [rtl/ldr_unit_cfg.sv]
// One logical unit's configuration bank: base, activate, level, channel.
// Assumes the top qualifies writes with the selected unit.
`default_nettype none
`include "ldr_cfg.svh"
module ldr_unit_cfg (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr,
    input wire logic [7:0] idx,
    input wire logic [7:0] wdata,
    output logic active,
    output logic [15:0] base,
    output logic [3:0] irq_sel,
    output logic [2:0] dma_sel,
    output logic [7:0] rdata
);
    import ldr_pkg::*;

    // Bank registers, cleared by the hardware reset except the channel field, which loads 4
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
            base <= 16'h0000;
            irq_sel <= 4'(`LDR_IRQ_RST);
            dma_sel <= 3'(`LDR_DMA_RST);
        end else if (wr) begin
            unique case (idx)
                `LDR_IDX_ACTIVATE: active <= wdata[0];
                `LDR_IDX_BASE_HI: base[15:8] <= wdata;
                `LDR_IDX_BASE_LO: base[7:0] <= wdata;
                `LDR_IDX_IRQ_SEL: irq_sel <= wdata[3:0];
                `LDR_IDX_DMA_SEL: dma_sel <= wdata[2:0];
                default: ;
            endcase
        end
    end

    // Read back; unimplemented indexes return zero
    always_comb begin
        unique case (idx)
            `LDR_IDX_ACTIVATE: rdata = {7'h00, active};
            `LDR_IDX_BASE_HI: rdata = base[15:8];
            `LDR_IDX_BASE_LO: rdata = base[7:0];
            `LDR_IDX_IRQ_SEL: rdata = {4'h0, irq_sel};
            `LDR_IDX_DMA_SEL: rdata = {5'h00, dma_sel};
            default: rdata = 8'h00;
        endcase
    end
endmodule : ldr_unit_cfg
`default_nettype wire

// [verification/ldr_pic_model.sv]
// Interrupt and DMA controller model facing the routed request pins.
// Assumes the bench clock; a released line shows a toggling pattern.
`default_nettype none
module ldr_pic_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] irq_o,
    input wire logic [15:0] irq_oe,
    input wire logic [3:0] dreq_o,
    input wire logic [3:0] dreq_oe,
    output logic [15:0] irq_line,
    output logic [3:0] dreq_line,
    output logic [15:0][7:0] irq_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk;
    logic [15:0] prev_line;
    logic [15:0] prev_oe;

    // Undriven lines wander so a stale value never passes for a drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            junk <= 1'b0;
        end else begin
            junk <= ~junk;
        end
    end

    assign irq_line = (irq_o & irq_oe) | ({16{junk}} & ~irq_oe);
    assign dreq_line = (dreq_o & dreq_oe) | ({4{junk}} & ~dreq_oe);

    // count rising edges on driven lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_line <= '0;
            prev_oe <= '0;
            irq_edges <= '0;
        end else begin
            prev_line <= irq_line;
            prev_oe <= irq_oe;
            for (int i = 0; i < 16; i++) begin
                if (irq_oe[i] & prev_oe[i] & irq_line[i] & ~prev_line[i]) begin
                    irq_edges[i] <= irq_edges[i] + 8'h01;
                end
            end
        end
    end
endmodule : ldr_pic_model
`default_nettype wire

// [verification/ldr_routing_tb_top.sv]
// Bench for the resource routing block: config port accesses and checks.
// Assumes the controller model file and the rtl package are compiled first.
`default_nettype none
`include "ldr_cfg.svh"
module ldr_routing_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ldr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] io_addr = '0;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [7:0] io_wdata = '0;
    logic cfg_mode = 1'b1;
    logic serial_irq_mode = 1'b1;
    logic mgmt_irq_req = 1'b0;
    logic mgmt_irq_enable = 1'b0;
    logic fgate = 1'b1;
    logic par_parallel_irq_enable = 1'b0;
    ldr_pmode_e parallel_mode = LDR_PM_SPP;
    logic svc = 1'b0;
    logic ext_dma = 1'b0;
    logic [3:0] s1_ie = '0;
    logic [3:0] s2_ie = '0;
    logic s1_aux = 1'b0;
    logic s2_aux = 1'b0;
    logic ir_dma = 1'b0;
    logic [4:0] unit_irq_req = 5'h1f;
    logic [2:0] unit_dma_req = 3'h7;
    logic [7:0] io_rdata;
    logic io_rdata_valid;
    logic [4:0] unit_sel;
    logic [2:0] unit_reg_ofs;
    logic epp_avail;
    logic [15:0] irq_o;
    logic [15:0] irq_oe;
    logic [3:0] dreq_o;
    logic [3:0] dreq_oe;
    logic mgmt_interrupt_n;
    logic [15:0] irq_line;
    logic [3:0] dreq_line;
    logic [15:0][7:0] irq_edges;
    logic [4:0] sel_q;
    logic [8:0] rd_q;
    logic [15:0] e;
    logic [15:0] pm = `LDR_PAR_IRQ_MASK;
    int fails = 0;
    int checks = 0;

    always #5 clk = ~clk;

    ldr_routing i_ldr_routing (.clk(clk), .rst(rst), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .cfg_mode(cfg_mode), .serial_irq_mode(serial_irq_mode),
        .mgmt_irq_req(mgmt_irq_req), .mgmt_irq_enable(mgmt_irq_enable),
        .floppy_dma_irq_gate(fgate), .parallel_irq_enable(par_parallel_irq_enable),
        .parallel_mode(parallel_mode), .service_interrupt_bit(svc),
        .ext_dma_enable(ext_dma), .serial1_int_enable(s1_ie),
        .serial2_int_enable(s2_ie), .serial1_aux_output_two(s1_aux),
        .serial2_aux_output_two(s2_aux), .infrared_dma_enable(ir_dma),
        .unit_irq_req(unit_irq_req), .unit_dma_req(unit_dma_req),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .unit_sel(unit_sel), .unit_reg_ofs(unit_reg_ofs),
        .epp_avail(epp_avail), .irq_o(irq_o), .irq_oe(irq_oe),
        .dreq_o(dreq_o), .dreq_oe(dreq_oe),
        .mgmt_interrupt_n(mgmt_interrupt_n));

    ldr_pic_model i_ldr_pic_model (.clk(clk), .rst(rst), .irq_o(irq_o),
        .irq_oe(irq_oe), .dreq_o(dreq_o), .dreq_oe(dreq_oe),
        .irq_line(irq_line), .dreq_line(dreq_line), .irq_edges(irq_edges));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Strobe raised after one edge, held across the next (taking) edge and dropped at it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : wr

    // Read strobe; answers are registered, so look just after the next edge
    task automatic acc(input logic [15:0] a);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        sel_q = unit_sel;
        rd_q = {io_rdata_valid, io_rdata};
    endtask : acc

    task automatic cfg(input logic [7:0] i, input logic [7:0] d);
        wr(16'h03f0, i);
        wr(16'h03f1, d);
    endtask : cfg

    task automatic rdcfg(input logic [7:0] i, input logic [7:0] x);
        wr(16'h03f0, i);
        acc(16'h03f1);
        check(16'(rd_q), {7'h00, 1'b1, x});
    endtask : rdcfg

    task automatic setup(input logic [7:0] u, input logic [15:0] b);
        cfg(8'h07, u);
        cfg(8'h60, b[15:8]);
        cfg(8'h61, b[7:0]);
        cfg(8'h30, 8'h01);
    endtask : setup

    task automatic dec(input logic [15:0] a, input logic [4:0] x);
        acc(a);
        check(16'(sel_q), 16'(x));
        check(16'(unit_reg_ofs), 16'(a[2:0]));
    endtask : dec

    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle

    task automatic close_out;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200us;
        fails++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cfg(8'h07, 8'h05);
        rdcfg(8'h70, 8'h00);
        rdcfg(8'h74, 8'h04);
        rdcfg(8'h75, 8'h00);
        cfg(8'h70, 8'hf3);
        rdcfg(8'h70, 8'h03);
        @(posedge clk);
        cfg_mode <= 1'b0;
        cfg(8'h70, 8'h05);
        @(posedge clk);
        cfg_mode <= 1'b1;
        rdcfg(8'h70, 8'h03);
        $display("test registers done");
        setup(8'h00, 16'h0080);
        dec(16'h0080, 5'h00);
        setup(8'h00, 16'h0370);
        dec(16'h0375, 5'h01);
        dec(16'h0376, 5'h00);
        dec(16'hf377, 5'h01);
        cfg(8'h30, 8'h00);
        dec(16'h0375, 5'h00);
        setup(8'h03, 16'h0278);
        dec(16'h027c, 5'h02);
        check(16'(epp_avail), 16'h0001);
        for (int k = 0; k < 3; k++) begin
            dec(16'h0678 + 16'(k), 5'h02);
        end
        cfg(8'h61, 8'h7c);
        dec(16'h027f, 5'h02);
        dec(16'h0280, 5'h00);
        check(16'(epp_avail), 16'h0000);
        setup(8'h04, 16'h03f8);
        for (int k = 0; k < 9; k++) begin
            dec(16'h03f8 + 16'(k), k < 8 ? 5'h04 : 5'h00);
        end
        setup(8'h07, 16'h0000);
        dec(16'h0060, 5'h10);
        dec(16'h0064, 5'h10);
        dec(16'h0062, 5'h00);
        $display("test decode done");
        // Management interrupt kept off while line two is in use
        setup(8'h00, 16'h0370);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            serial_irq_mode <= m[0];
            for (int n = 0; n < 16; n++) begin
                cfg(8'h70, 8'(n));
                settle();
                e = (n != 0 && (m == 1 || pm[n])) ? 16'h0001 << n : '0;
                check(irq_oe, e);
                check(irq_line & e, e);
            end
        end
        cfg(8'h70, 8'h05);
        e = 16'(irq_edges[5]) + 16'h0001;
        @(posedge clk);
        unit_irq_req[0] <= 1'b0;
        @(posedge clk);
        unit_irq_req[0] <= 1'b1;
        repeat (2) settle();
        check(16'(irq_edges[5]), e);
        @(posedge clk);
        fgate <= 1'b0;
        settle();
        check(irq_oe, 16'h0000);
        @(posedge clk);
        fgate <= 1'b1;
        mgmt_irq_enable <= 1'b1;
        mgmt_irq_req <= 1'b1;
        cfg(8'h70, 8'h02);
        settle();
        check(irq_oe, 16'h0000);
        check(16'(mgmt_interrupt_n), 16'h0000);
        @(posedge clk);
        mgmt_irq_req <= 1'b0;
        settle();
        check(16'(mgmt_interrupt_n), 16'h0001);
        $display("test floppy irq done");
        for (int c = 0; c < 8; c++) begin
            cfg(8'h74, 8'(c));
            settle();
            e = (c > 0 && c < 4) ? 16'h0001 << c : '0;
            check(16'(dreq_oe), e);
        end
        cfg(8'h74, 8'h02);
        @(posedge clk);
        fgate <= 1'b0;
        settle();
        check(16'(dreq_oe), 16'h0000);
        cfg(8'h30, 8'h00);
        $display("test floppy dma done");
        cfg(8'h07, 8'h03);
        cfg(8'h70, 8'h07);
        cfg(8'h74, 8'h01);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            par_parallel_irq_enable <= k > 0;
            parallel_mode <= k > 1 ? LDR_PM_ECP : LDR_PM_SPP;
            svc <= k == 2;
            ext_dma <= k == 3;
            settle();
            check(irq_oe, (k == 1 || k == 3) ? 16'h0080 : '0);
            if (k > 1) begin
                check(16'(dreq_oe), k == 3 ? 16'h0002 : '0);
            end
        end
        $display("test parallel done");
        cfg(8'h07, 8'h04);
        cfg(8'h70, 8'h04);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            s1_ie <= k > 0 ? 4'h8 : 4'h0;
            // Parallel unit still routes line 7 and channel 1: quiet it
            par_parallel_irq_enable <= 1'b0;
            ext_dma <= 1'b0;
            s1_aux <= k != 1;
            settle();
            check(irq_oe, k == 2 ? 16'h0010 : '0);
        end
        setup(8'h05, 16'h02f8);
        cfg(8'h74, 8'h03);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ir_dma <= k[0];
            settle();
            check(16'(dreq_oe), k == 1 ? 16'h0008 : '0);
            check(16'(dreq_line & dreq_oe), k == 1 ? 16'h0008 : '0);
        end
        $display("test serial done");
        close_out();
    end
endmodule : ldr_routing_tb_top
`default_nettype wire
